// ### core/ctmc_mode_ctrl.sv
// Transceiver mode control and digital pin path.
// Operation
// - Power-up starts in off mode; off allowed always; bus pins high impedance.
// - Off mode ignores bus activity for wake and raises no wake indication.
// - Mode is chosen by the serial mode field, but failsafe or leaving normal/stop forces wake-capable; no pin selection.
// - Normal mode enabled in normal system mode, kept in normal and stop.
// - Normal mode biases the bus at half the transceiver supply.
// - Normal mode drives the bus from the transmit input; low is dominant.
// - Low input during enable time sends nothing until next fresh dominant bit.
// - Receive output shows the differential bus state while reception is active.
// - Receive-only disables the driver, keeps reception and bias; normal or stop.
// - Paths carry bus signalling up to 2 Mbaud.
// - Wake-capable mode: a bus wake drives receive output low until mode change or the system enters a low-power mode.
// - Mode field reads back wake-capable value after a bus wake.
// - Dominant time-out disables transmitter, sets fault, recovers on release.
`timescale 1ns/10ps
`include "ctmc_consts.svh"
module ctmc_mode_ctrl #(
  parameter logic [`CTMC_MODE_W-1:0] MODE_OFF = `CTMC_MODE_OFF,
  parameter logic [`CTMC_MODE_W-1:0] MODE_WAKE = `CTMC_MODE_WAKE,
  parameter logic [`CTMC_MODE_W-1:0] MODE_NORMAL = `CTMC_MODE_NORMAL,
  parameter logic [`CTMC_MODE_W-1:0] MODE_RXONLY = `CTMC_MODE_RXONLY,
  parameter int EN_CYC = `CTMC_EN_CYC,
  parameter int TO_CYC = `CTMC_TO_CYC
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [`CTMC_MODE_W-1:0] i_mode_field,
  input wire logic i_mode_write,
  input wire logic [`CTMC_SYS_W-1:0] i_sys_mode,
  input wire logic i_transmit_input_pin,
  input wire logic i_bus_diff_dom,
  input wire logic i_fault_clear,
  output logic o_receive_pin,
  output ctmc_pkg::ctmc_bus_ctrl_t o_bus,
  output logic [`CTMC_MODE_W-1:0] o_mode_readback,
  output logic o_wake_flag,
  output logic o_dom_fault
);
  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] txd_sync_reg;
  logic [1:0] bus_sync_reg;
  logic txd_dom;
  logic bus_dom;
  // Both pins are asynchronous; at 100 MHz two stages add 20 ns, far below a 2 Mbaud bit.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      txd_sync_reg <= 2'h3;
      bus_sync_reg <= 2'h0;
    end else begin
      txd_sync_reg <= {txd_sync_reg[0], i_transmit_input_pin};
      bus_sync_reg <= {bus_sync_reg[0], i_bus_diff_dom};
    end
  end
  assign txd_dom = !txd_sync_reg[1];
  assign bus_dom = bus_sync_reg[1];

  // ----------------------------------------------------------------
  // Mode state
  // ----------------------------------------------------------------
  ctmc_pkg::ctmc_state_t state_reg;
  ctmc_pkg::ctmc_state_t state_next;
  logic [`CTMC_MODE_W-1:0] field_reg;
  logic sys_active;
  logic sys_lowpwr;
  logic sys_mode_prev_lowpwr_reg;
  assign sys_active = (i_sys_mode == `CTMC_SYS_NORMAL) || (i_sys_mode == `CTMC_SYS_STOP);
  assign sys_lowpwr = (i_sys_mode == `CTMC_SYS_STOP) || (i_sys_mode == `CTMC_SYS_SLEEP) ||
                      (i_sys_mode == `CTMC_SYS_FAILSAFE);

  always_comb begin
    state_next = state_reg;
    if (i_mode_write) begin
      if (i_mode_field == MODE_OFF) begin
        state_next = ctmc_pkg::CTMC_ST_OFF;
      end else if (i_mode_field == MODE_WAKE) begin
        state_next = ctmc_pkg::CTMC_ST_WAKE;
      end else if (i_mode_field == MODE_NORMAL) begin
        if (i_sys_mode == `CTMC_SYS_NORMAL) begin
          state_next = ctmc_pkg::CTMC_ST_NORMAL;
        end
      end else if (i_mode_field == MODE_RXONLY) begin
        if (sys_active) begin
          state_next = ctmc_pkg::CTMC_ST_RXONLY;
        end
      end
    end else if (i_sys_mode == `CTMC_SYS_FAILSAFE) begin
      state_next = ctmc_pkg::CTMC_ST_WAKE;
    end else if (!sys_active && (state_reg == ctmc_pkg::CTMC_ST_NORMAL ||
                                 state_reg == ctmc_pkg::CTMC_ST_RXONLY)) begin
      state_next = ctmc_pkg::CTMC_ST_WAKE;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= ctmc_pkg::CTMC_ST_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  // Field readback follows the next mode state, so wake-capable still reads back after a wake.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      field_reg <= MODE_OFF;
    end else begin
      case (state_next)
        ctmc_pkg::CTMC_ST_OFF: field_reg <= MODE_OFF;
        ctmc_pkg::CTMC_ST_WAKE: field_reg <= MODE_WAKE;
        ctmc_pkg::CTMC_ST_NORMAL: field_reg <= MODE_NORMAL;
        ctmc_pkg::CTMC_ST_RXONLY: field_reg <= MODE_RXONLY;
        default: field_reg <= MODE_OFF;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Enable time and first dominant bit
  // ----------------------------------------------------------------
  logic [15:0] en_cnt_reg;
  logic tx_armed_reg;
  logic entering_normal;
  assign entering_normal = (state_next == ctmc_pkg::CTMC_ST_NORMAL) &&
                           (state_reg != ctmc_pkg::CTMC_ST_NORMAL);
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      en_cnt_reg <= 16'h0000;
    end else if (entering_normal) begin
      en_cnt_reg <= 16'(EN_CYC);
    end else if (en_cnt_reg != 16'h0000) begin
      en_cnt_reg <= en_cnt_reg - 16'h0001;
    end
  end
  // Transmission is armed only by a recessive input after the enable time, so a
  // dominant level already held then is never put on the bus.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      tx_armed_reg <= 1'b0;
    end else if (state_reg != ctmc_pkg::CTMC_ST_NORMAL || entering_normal) begin
      tx_armed_reg <= 1'b0;
    end else if (en_cnt_reg == 16'h0000 && !txd_dom) begin
      tx_armed_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Dominant time-out
  // ----------------------------------------------------------------
  logic [31:0] to_cnt_reg;
  logic to_active_reg;
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      to_cnt_reg <= 32'h00000000;
      to_active_reg <= 1'b0;
    end else if (state_reg != ctmc_pkg::CTMC_ST_NORMAL || !txd_dom) begin
      to_cnt_reg <= 32'h00000000;
      to_active_reg <= 1'b0;
    end else if (to_cnt_reg >= 32'(TO_CYC)) begin
      to_active_reg <= 1'b1;
    end else begin
      to_cnt_reg <= to_cnt_reg + 32'h00000001;
    end
  end
  // The fault stays until cleared; a new time-out in the clearing cycle wins.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_dom_fault <= 1'b0;
    end else if (to_active_reg) begin
      o_dom_fault <= 1'b1;
    end else if (i_fault_clear) begin
      o_dom_fault <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Wake detection
  // ----------------------------------------------------------------
  logic wake_arm;
  logic wake_hit;
  logic rearm_reg;
  assign wake_arm = (state_reg == ctmc_pkg::CTMC_ST_WAKE) && !o_wake_flag;
  ctmc_wake_detect u_wake (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_arm(wake_arm),
    .i_bus_dom(bus_dom),
    .o_wake(wake_hit)
  );
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      sys_mode_prev_lowpwr_reg <= 1'b0;
    end else begin
      sys_mode_prev_lowpwr_reg <= sys_lowpwr;
    end
  end
  assign rearm_reg = sys_lowpwr && !sys_mode_prev_lowpwr_reg;
  // Wake stays latched until the mode changes or the system enters a low-power mode.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_wake_flag <= 1'b0;
    end else if (state_reg != ctmc_pkg::CTMC_ST_WAKE) begin
      o_wake_flag <= 1'b0;
    end else if (wake_hit) begin
      o_wake_flag <= 1'b1;
    end else if (rearm_reg || state_next != ctmc_pkg::CTMC_ST_WAKE) begin
      o_wake_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Registered pin outputs
  // ----------------------------------------------------------------
  logic rx_active;
  assign rx_active = (state_reg == ctmc_pkg::CTMC_ST_NORMAL) ||
                     (state_reg == ctmc_pkg::CTMC_ST_RXONLY);
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_bus <= '0;
      o_receive_pin <= 1'b1;
      o_mode_readback <= MODE_OFF;
    end else begin
      o_mode_readback <= field_reg;
      o_bus.bias_half <= rx_active;
      o_bus.bias_gnd <= (state_reg == ctmc_pkg::CTMC_ST_WAKE);
      o_bus.bus_drive_en <= (state_reg == ctmc_pkg::CTMC_ST_NORMAL) && tx_armed_reg &&
                            !to_active_reg;
      o_bus.bus_dominant <= (state_reg == ctmc_pkg::CTMC_ST_NORMAL) && txd_dom && tx_armed_reg &&
                            !to_active_reg;
      if (rx_active) begin
        o_receive_pin <= !bus_dom;
      end else if (state_reg == ctmc_pkg::CTMC_ST_WAKE && o_wake_flag) begin
        o_receive_pin <= 1'b0;
      end else begin
        o_receive_pin <= 1'b1;
      end
    end
  end
endmodule : ctmc_mode_ctrl

// ### core/ctmc_consts.svh
// Constants for the transceiver mode control block.
`ifndef CTMC_CONSTS_SVH
`define CTMC_CONSTS_SVH
`define CTMC_CLK_MHZ 100
`define CTMC_MODE_W 2
`define CTMC_MODE_OFF 2'h0
`define CTMC_MODE_WAKE 2'h1
`define CTMC_MODE_NORMAL 2'h2
`define CTMC_MODE_RXONLY 2'h3
`define CTMC_SYS_W 3
`define CTMC_SYS_NORMAL 3'h0
`define CTMC_SYS_STOP 3'h1
`define CTMC_SYS_SLEEP 3'h2
`define CTMC_SYS_RESTART 3'h3
`define CTMC_SYS_FAILSAFE 3'h4
`define CTMC_EN_TIME_US 10
`define CTMC_EN_CYC ((`CTMC_EN_TIME_US * `CTMC_CLK_MHZ))
`define CTMC_TO_TIME_US 1000
`define CTMC_TO_CYC ((`CTMC_TO_TIME_US * `CTMC_CLK_MHZ))
`define CTMC_WAKE_TIME_NS 500
`define CTMC_WAKE_CYC ((`CTMC_WAKE_TIME_NS * `CTMC_CLK_MHZ + 999) / 1000)
`endif

// ### core/ctmc_pkg.sv
// Types shared by the transceiver mode control block.
package ctmc_pkg;
  typedef enum logic [1:0] {
    CTMC_ST_OFF,
    CTMC_ST_WAKE,
    CTMC_ST_NORMAL,
    CTMC_ST_RXONLY
  } ctmc_state_t;
  typedef struct packed {
    logic bus_drive_en;
    logic bus_dominant;
    logic bias_half;
    logic bias_gnd;
  } ctmc_bus_ctrl_t;
endpackage : ctmc_pkg

// ### core/ctmc_wake_detect.sv
// Bus wake-up pattern detector: two dominant phases split by a recessive one.
`timescale 1ns/10ps
`include "ctmc_consts.svh"
module ctmc_wake_detect #(
  parameter int FILT_CYC = `CTMC_WAKE_CYC
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_arm,
  input wire logic i_bus_dom,
  output logic o_wake
);
  logic [15:0] cnt_reg;
  logic prev_reg;
  logic [1:0] phase_reg;
  // Counts how long the bus has held its present level.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      cnt_reg <= 16'h0000;
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= i_bus_dom;
      if (!i_arm || prev_reg != i_bus_dom) begin
        cnt_reg <= 16'h0000;
      end else if (cnt_reg != 16'hFFFF) begin
        cnt_reg <= cnt_reg + 16'h0001;
      end
    end
  end
  // Phases seen: 1 dominant, 2 dominant+recessive, 3 pattern complete.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      phase_reg <= 2'h0;
    end else if (!i_arm) begin
      phase_reg <= 2'h0;
    end else if (prev_reg != i_bus_dom && cnt_reg >= 16'(FILT_CYC)) begin
      if (prev_reg && phase_reg == 2'h0) begin
        phase_reg <= 2'h1;
      end else if (!prev_reg && phase_reg == 2'h1) begin
        phase_reg <= 2'h2;
      end else if (prev_reg && phase_reg == 2'h2) begin
        phase_reg <= 2'h3;
      end
    end
  end
  assign o_wake = (phase_reg == 2'h3);
endmodule : ctmc_wake_detect

// ### dv/ctmc_mode_ctrl_properties.sv
// Port-level checks for the transceiver mode control block.
`timescale 1ns/10ps
`include "ctmc_consts.svh"
module ctmc_mode_ctrl_checker #(
  parameter int TO_CYC = 200
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_transmit_input_pin,
  input wire logic i_bus_diff_dom,
  input wire logic o_receive_pin,
  input wire ctmc_pkg::ctmc_bus_ctrl_t o_bus,
  input wire logic [`CTMC_MODE_W-1:0] o_mode_readback,
  input wire logic o_wake_flag,
  input wire logic o_dom_fault
);
  localparam logic [1:0] OFF = `CTMC_MODE_OFF;
  localparam logic [1:0] WAKE = `CTMC_MODE_WAKE;
  localparam logic [1:0] NORM = `CTMC_MODE_NORMAL;
  localparam logic [1:0] RXO = `CTMC_MODE_RXONLY;
  logic [15:0] cnt_reg;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // ----------------------------------------
  // Dominant drive length counter
  // ----------------------------------------
  // A stuck transmit pin must never hold the bus beyond the time-out.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      cnt_reg <= 16'h0000;
    end else if (o_bus.bus_drive_en && o_bus.bus_dominant) begin
      cnt_reg <= cnt_reg + 16'h0001;
    end else begin
      cnt_reg <= 16'h0000;
    end
  end
  a_off_quiet: assert property (o_mode_readback == OFF |-> o_bus == 4'h0)
    else $error("Bus not released in off mode");
  a_off_no_wake: assert property (o_mode_readback == OFF && $past(o_mode_readback) == OFF |-> !o_wake_flag)
    else $error("Wake flag raised in off mode");
  a_normal_bias: assert property (o_mode_readback == NORM |-> o_bus.bias_half && !o_bus.bias_gnd)
    else $error("Normal mode bias wrong");
  a_rxonly_no_drive: assert property (o_mode_readback == RXO |-> !o_bus.bus_drive_en && o_bus.bias_half)
    else $error("Receive-only mode drives or lacks bias");
  a_tx_follows: assert property (o_bus.bus_drive_en && $past(o_bus.bus_drive_en)
    |-> o_bus.bus_dominant == !$past(i_transmit_input_pin, 3))
    else $error("Bus drive does not follow transmit pin");
  a_rx_follows: assert property ((o_mode_readback == RXO && $past(o_mode_readback, 4) == RXO)
    |-> o_receive_pin == !$past(i_bus_diff_dom, 3))
    else $error("Receive pin does not follow bus");
  a_wake_rx_low: assert property ($rose(o_wake_flag) |=> !o_receive_pin)
    else $error("Receive pin not low after wake");
  a_wake_readback: assert property ($rose(o_wake_flag) |-> (o_mode_readback == WAKE) [*3])
    else $error("Mode readback changed by wake");
  a_dom_bounded: assert property (cnt_reg <= 16'(TO_CYC + 3))
    else $error("Dominant drive outlasts time-out");
  c_wake: cover property ($rose(o_wake_flag));
  c_fault: cover property ($rose(o_dom_fault));
  c_drive: cover property (o_bus.bus_drive_en && o_bus.bus_dominant);
endmodule : ctmc_mode_ctrl_checker

// ### dv/ctmc_can_ctrl_model.sv
// Protocol controller model driving the transmit pin.
`timescale 1ns/10ps
module ctmc_can_ctrl_model (
  input wire logic i_mclk,
  output logic o_txd
);
  // ----------------------------------------
  // Transmit pin driver
  // ----------------------------------------
  initial o_txd = 1'h1;
  // Keeps the pin recessive, as after a mode change during enable time.
  task automatic hold_rec(input int n);
    drive(1'h1, n);
  endtask : hold_rec
  task automatic drive(input logic b, input int n);
    o_txd = b;
    repeat (n) @(posedge i_mclk);
    #1;
  endtask : drive
endmodule : ctmc_can_ctrl_model

// ### dv/ctmc_mode_ctrl_bench.sv
// Self-checking bench for the transceiver mode control block.
`timescale 1ns/10ps
`include "ctmc_consts.svh"
module ctmc_mode_ctrl_bench;
  localparam logic [1:0] OFF = `CTMC_MODE_OFF;
  localparam logic [1:0] WAKE = `CTMC_MODE_WAKE;
  localparam logic [1:0] NORM = `CTMC_MODE_NORMAL;
  localparam logic [1:0] RXO = `CTMC_MODE_RXONLY;
  logic i_mclk, i_rst, i_mode_write, i_fault_clear, txd, ext_dom, r;
  logic o_receive_pin, o_wake_flag, o_dom_fault;
  logic [1:0] i_mode_field, o_mode_readback;
  logic [2:0] i_sys_mode;
  ctmc_pkg::ctmc_bus_ctrl_t o_bus;
  wire logic bus_dom = (o_bus.bus_drive_en & o_bus.bus_dominant) | ext_dom;
  int n_mismatch = 0;
  int checked = 0;
  ctmc_mode_ctrl #(.EN_CYC(20), .TO_CYC(200)) i_ctmc_mode_ctrl (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_mode_field(i_mode_field),
    .i_mode_write(i_mode_write), .i_sys_mode(i_sys_mode), .i_transmit_input_pin(txd),
    .i_bus_diff_dom(bus_dom), .i_fault_clear(i_fault_clear), .o_receive_pin(o_receive_pin),
    .o_bus(o_bus), .o_mode_readback(o_mode_readback), .o_wake_flag(o_wake_flag),
    .o_dom_fault(o_dom_fault));
  ctmc_can_ctrl_model i_ctmc_can_ctrl_model (.i_mclk(i_mclk), .o_txd(txd));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic dom_exp(input logic pin);
    return !pin;
  endfunction : dom_exp
  task automatic cyc(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask : cyc
  task automatic chk_bit(input logic got, input logic exp, input string what);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: %s got %b", $time, what, got);
    end
  endtask : chk_bit
  task automatic chk_mode(input logic [1:0] got, input logic [1:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: readback %h expected %h", $time, got, exp);
    end
  endtask : chk_mode
  task automatic wr(input logic [1:0] m);
    i_mode_field = m;
    i_mode_write = 1'h1;
    cyc(1);
    i_mode_write = 1'h0;
    cyc(3);
  endtask : wr
  task automatic wup();
    ext_dom = 1'h1;
    cyc(60);
    ext_dom = 1'h0;
    cyc(60);
    ext_dom = 1'h1;
    cyc(60);
    ext_dom = 1'h0;
    cyc(5);
  endtask : wup
  task automatic tally_and_finish();
    $display("Counts: %0d compares, %0d mismatches", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    i_mclk = 1'h0;
    forever #5 i_mclk = ~i_mclk;
  end
  initial begin
    #100000;
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    i_rst = 1'h1;
    i_mode_field = OFF;
    i_mode_write = 1'h0;
    i_sys_mode = `CTMC_SYS_NORMAL;
    i_fault_clear = 1'h0;
    ext_dom = 1'h0;
    void'($urandom(32'h3837));
    cyc(3);
    i_rst = 1'h0;
    cyc(1);
    chk_mode(o_mode_readback, OFF);
    chk_bit(o_bus == 4'h0, 1'h1, "bus idle");
    wup();
    chk_bit(o_wake_flag, 1'h0, "off wake");
    i_sys_mode = ($urandom_range(1, 0) == 0) ? `CTMC_SYS_SLEEP : `CTMC_SYS_RESTART;
    wr(NORM);
    wr(RXO);
    chk_mode(o_mode_readback, OFF);
    i_sys_mode = `CTMC_SYS_NORMAL;
    wr(NORM);
    chk_mode(o_mode_readback, NORM);
    chk_bit(o_bus.bias_half, 1'h1, "bias");
    $display("Test reset and mode select done");
    // The controller misbehaves on purpose: low during the enable time.
    i_ctmc_can_ctrl_model.drive(1'h0, 30);
    chk_bit(bus_dom, 1'h0, "early low");
    i_ctmc_can_ctrl_model.hold_rec(5);
    i_ctmc_can_ctrl_model.drive(1'h0, 5);
    chk_bit(bus_dom, 1'h1, "next dominant");
    i_ctmc_can_ctrl_model.hold_rec(10);
    $display("Test enable sequence done");
    for (int i = 0; i < 16; i++) begin
      r = 1'($urandom);
      // A recessive bit every third keeps dominant runs short of the time-out.
      if (i % 3 == 2) r = 1'h1;
      i_ctmc_can_ctrl_model.drive(r, 25);
      chk_bit(bus_dom, dom_exp(r), "tx bit");
      chk_bit(o_receive_pin, !dom_exp(r), "rx bit");
      i_ctmc_can_ctrl_model.drive(r, 25);
    end
    $display("Test traffic done");
    i_ctmc_can_ctrl_model.drive(1'h0, 220);
    chk_bit(o_bus.bus_drive_en, 1'h0, "timeout drive");
    chk_bit(o_dom_fault, 1'h1, "timeout flag");
    i_ctmc_can_ctrl_model.hold_rec(10);
    chk_bit(o_bus.bus_drive_en, 1'h1, "recover");
    chk_mode(o_mode_readback, NORM);
    i_fault_clear = 1'h1;
    cyc(1);
    i_fault_clear = 1'h0;
    cyc(2);
    chk_bit(o_dom_fault, 1'h0, "fault clear");
    $display("Test time-out done");
    i_sys_mode = ($urandom_range(1, 0) == 0) ? `CTMC_SYS_NORMAL : `CTMC_SYS_STOP;
    wr(RXO);
    i_ctmc_can_ctrl_model.drive(1'h0, 1);
    for (int i = 0; i < 8; i++) begin
      ext_dom = 1'($urandom);
      cyc(5);
      chk_bit(o_receive_pin, !ext_dom, "rxonly rx");
      chk_bit(o_bus.bus_drive_en, 1'h0, "rxonly drive");
    end
    i_ctmc_can_ctrl_model.hold_rec(1);
    ext_dom = 1'h0;
    $display("Test receive-only done");
    wr(WAKE);
    wup();
    chk_bit(o_wake_flag, 1'h1, "wake flag");
    chk_bit(o_receive_pin, 1'h0, "wake rx");
    chk_mode(o_mode_readback, WAKE);
    wr(OFF);
    chk_bit(o_bus == 4'h0, 1'h1, "off again");
    $display("Test wake done");
    tally_and_finish();
  end
endmodule : ctmc_mode_ctrl_bench
bind ctmc_mode_ctrl ctmc_mode_ctrl_checker #(.TO_CYC(TO_CYC)) i_chk (
  .i_mclk(i_mclk), .i_rst(i_rst), .i_transmit_input_pin(i_transmit_input_pin),
  .i_bus_diff_dom(i_bus_diff_dom), .o_receive_pin(o_receive_pin), .o_bus(o_bus),
  .o_mode_readback(o_mode_readback), .o_wake_flag(o_wake_flag), .o_dom_fault(o_dom_fault));
